// ==== pcw_clock_path_ctrl.sv ====
// APB register block holding the 40-bit clock-path control word and its decoded controls.
//
// Contract
// RULE1: Software writes all five bytes together.
// RULE2: Bit 39 powers down converter, output floats.
// RULE3: Software writes zeros in 38:34 and 7:6.
// RULE4: Bit 33 powers down band gap; slow recovery.
// RULE5: Bit 32 selects internal driver current resistor.
// RULE6: Bits 31:29 add rising-edge surge currents.
// RULE7: Bits 28:26 add falling-edge surge currents.
// RULE8: Bit 25 routes lock detect to pin.
// RULE9: Bit 24 selects lock or lead-lag meaning.
// RULE10: Bit 23 powers down RF divider, alternate path.
// RULE11: Bits 22:21 pick RF divide 1/2/4/8.
// RULE12: Bit 20 high keeps output driver down.
// RULE13: Bits 19:18 select output driver source.
// RULE14: Bit 17 removes every edge surge current.
// RULE15: Bit 16 bypasses RF divider for system clock.
// RULE16: Reference divider M is field plus one.
// RULE17: Feedback divider N is field plus one.
// RULE18: Bit 5 reverses charge-pump polarity.
// RULE19: Bit 4 fully powers down charge pump.
// RULE20: Bit 3 powers down pump output buffer only.
// RULE21: Charge-pump current scale is field plus one.
// RULE22: Controls update together after complete write.
module pcw_clock_path_ctrl #(
  parameter int BG_SETTLE_CYCLES = pcw_pkg::PCW_BG_SETTLE_CYCLES  // Band-gap settle time in cycles.
) (
  input  wire logic        clk,               // System clock, 100 MHz.
  input  wire logic        nrst,              // Asynchronous reset, active low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB enable.
  input  wire logic        pwrite,            // APB direction, high for write.
  input  wire logic [7:0]  paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  input  wire logic [3:0]  pstrb,             // APB byte strobes.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error for unmapped address.
  input  wire logic        pll_locked,        // Loop lock state from the phase detector.
  input  wire logic        fb_lags_ref,       // Feedback clock lags the reference.
  output logic             status_pin_o,      // Lock-detect level for the shared pin.
  output logic             status_pin_oe,     // Drive enable of the shared pin.
  output logic             bg_ready,          // Band gap powered and settled.
  output logic             dac_pd,            // Converter powered down, output floating.
  output logic             bg_pd,             // Band gap powered down.
  output logic             drv_int_rset,      // Driver current from internal resistor.
  output logic      [2:0]  rise_surge,        // Extra rising-edge surge enables.
  output logic      [2:0]  fall_surge,        // Extra falling-edge surge enables.
  output logic             dflt_surge_en,     // Default edge surge applied.
  output logic             rfdiv_pd,          // RF divider down, alternate path on.
  output logic      [3:0]  rfdiv_value,       // RF divide ratio.
  output logic             drv_pd,            // Output driver powered down.
  output logic      [1:0]  drv_src,           // Output driver source select.
  output logic             sys_bypass,        // System clock taken from divider input.
  output logic      [4:0]  ref_div_m,         // Reference divide ratio.
  output logic      [4:0]  fb_div_n,          // Feedback divide ratio.
  output logic             cp_invert,         // Charge-pump polarity reversed.
  output logic             cp_pd,             // Charge pump fully down.
  output logic             cp_quick_pd,       // Charge-pump output buffer down.
  output logic      [4:0]  cp_scale           // Charge-pump current multiplier.
);

  localparam logic [pcw_pkg::PCW_BG_CNT_W-1:0] BG_LOAD = BG_SETTLE_CYCLES[pcw_pkg::PCW_BG_CNT_W-1:0];

  pcw_ctl_if if_c ();

  logic [39:0] word_r;
  logic [31:0] lo_stage_r;
  logic        lo_staged_r;
  logic        partial_r;
  logic        rsvd_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        status_o_r;
  logic        status_oe_r;
  logic        bg_ready_r;
  logic [pcw_pkg::PCW_BG_CNT_W-1:0] bg_cnt_r;
  logic [39:0] word_nxt;
  logic        setup;
  logic        done;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_stat;
  logic        full_lo;
  logic        commit;
  logic        partial_ev;
  logic        rsvd_ev;
  logic        mapped;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // Setup and completion strobes and the write targets.
  assign setup      = psel & ~penable;
  assign done       = psel & penable & pready_r;
  assign wr_lo      = done & pwrite & (paddr == pcw_pkg::PCW_OFS_LO);
  assign wr_hi      = done & pwrite & (paddr == pcw_pkg::PCW_OFS_HI);
  assign wr_stat    = done & pwrite & (paddr == pcw_pkg::PCW_OFS_STAT);
  assign full_lo    = (pstrb == 4'hF);
  assign mapped     = (paddr == pcw_pkg::PCW_OFS_LO) | (paddr == pcw_pkg::PCW_OFS_HI) |
                      (paddr == pcw_pkg::PCW_OFS_STAT);
  // The word commits only when the high byte follows a complete low word.
  assign commit     = wr_hi & pstrb[0] & lo_staged_r; // see RULE1
  assign partial_ev = (wr_lo & ~full_lo) | (wr_hi & ~(pstrb[0] & lo_staged_r)); // see RULE1
  assign word_nxt   = {pwdata[7:0], lo_stage_r};
  assign rsvd_ev    = commit & (|(word_nxt & pcw_pkg::PCW_RSVD_MASK)); // see RULE3

  // Ready rises for exactly one access cycle after each setup cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // Read data and error are prepared during setup and held through the access.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= ~mapped;
      prdata_r  <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          pcw_pkg::PCW_OFS_LO:   prdata_r <= word_r[31:0];
          pcw_pkg::PCW_OFS_HI:   prdata_r <= {24'h00_0000, word_r[39:32]};
          pcw_pkg::PCW_OFS_STAT: begin
            prdata_r[pcw_pkg::STAT_LO_STAGED] <= lo_staged_r;
            prdata_r[pcw_pkg::STAT_PARTIAL]   <= partial_r;
            prdata_r[pcw_pkg::STAT_RSVD]      <= rsvd_r;
            prdata_r[pcw_pkg::STAT_BG_READY]  <= bg_ready_r;
          end
          default:               prdata_r <= 32'h0000_0000;
        endcase
      end
    end else if (done) begin
      pslverr_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Staging and commit
  // ==========================================================================
  // A full low word is staged; any high-byte write or short write drops it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_stage_r  <= 32'h0000_0000;
      lo_staged_r <= 1'b0;
    end else if (wr_lo) begin
      lo_staged_r <= full_lo; // see RULE1
      if (full_lo) begin
        lo_stage_r <= pwdata;
      end
    end else if (wr_hi) begin
      lo_staged_r <= 1'b0;
    end
  end

  // The active word changes only on commit; reserved bits are stored as zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_r <= pcw_pkg::PCW_CTRL_RESET;
    end else if (commit) begin
      word_r <= word_nxt & ~pcw_pkg::PCW_RSVD_MASK; // see RULE22 RULE3
    end
  end

  assign if_c.word = word_r;

  // Sticky error flags; a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      partial_r <= 1'b0;
      rsvd_r    <= 1'b0;
    end else begin
      partial_r <= partial_ev | (partial_r & ~(wr_stat & pstrb[0] & pwdata[pcw_pkg::STAT_PARTIAL]));
      rsvd_r    <= rsvd_ev | (rsvd_r & ~(wr_stat & pstrb[0] & pwdata[pcw_pkg::STAT_RSVD]));
    end
  end

  // ==========================================================================
  // Decoder
  // ==========================================================================
  pcw_decoder u_dec (
    .clk  (clk),
    .nrst (nrst),
    .bus  (if_c)
  );

  // ==========================================================================
  // Band-gap settling
  // ==========================================================================
  // The settle count restarts while the band gap is down and runs out after power-up.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bg_cnt_r   <= BG_LOAD;
      bg_ready_r <= 1'b0;
    end else begin
      if (if_c.ctl.bg_pd) begin
        bg_cnt_r <= BG_LOAD; // see RULE4
      end else if (bg_cnt_r != '0) begin
        bg_cnt_r <= bg_cnt_r - 1'b1;
      end
      bg_ready_r <= ~if_c.ctl.bg_pd & (bg_cnt_r == '0);
    end
  end

  // ==========================================================================
  // Lock-detect pin
  // ==========================================================================
  // Locked shows low in status mode; lead-lag mode shows high while feedback lags.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_o_r  <= 1'b0;
      status_oe_r <= 1'b0;
    end else begin
      status_oe_r <= if_c.ctl.lock_en; // see RULE8
      status_o_r  <= if_c.ctl.lock_mode ? fb_lags_ref : ~pll_locked; // see RULE9
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output is a flip-flop of this module or of the decoder.
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign status_pin_o  = status_o_r;
  assign status_pin_oe = status_oe_r;
  assign bg_ready      = bg_ready_r;
  assign dac_pd        = if_c.ctl.dac_pd;
  assign bg_pd         = if_c.ctl.bg_pd;
  assign drv_int_rset  = if_c.ctl.drv_int_rset;
  assign rise_surge    = if_c.ctl.rise_surge;
  assign fall_surge    = if_c.ctl.fall_surge;
  assign dflt_surge_en = if_c.ctl.dflt_surge_en;
  assign rfdiv_pd      = if_c.ctl.rfdiv_pd;
  assign rfdiv_value   = if_c.ctl.rfdiv_value;
  assign drv_pd        = if_c.ctl.drv_pd;
  assign drv_src       = if_c.ctl.drv_src;
  assign sys_bypass    = if_c.ctl.sys_bypass;
  assign ref_div_m     = if_c.ctl.ref_div_m;
  assign fb_div_n      = if_c.ctl.fb_div_n;
  assign cp_invert     = if_c.ctl.cp_invert;
  assign cp_pd         = if_c.ctl.cp_pd;
  assign cp_quick_pd   = if_c.ctl.cp_quick_pd;
  assign cp_scale      = if_c.ctl.cp_scale;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // A short low-word write leaves nothing staged.
  property p_short_lo;
    (wr_lo && !full_lo) |=> !lo_staged_r;
  endproperty
  a_short_lo: assert property (p_short_lo) else $error("short low write left word staged"); // see RULE1

  // A high-byte write without a staged low word changes nothing.
  property p_hi_alone;
    (wr_hi && !lo_staged_r) |=> (word_r == $past(word_r)) ##1 (if_c.ctl == $past(if_c.ctl));
  endproperty
  a_hi_alone: assert property (p_hi_alone) else $error("lone high write changed the word"); // see RULE1

  // Reserved bits never reach the active word.
  property p_rsvd_zero;
    (word_r & pcw_pkg::PCW_RSVD_MASK) == 40'h00_0000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits stored"); // see RULE3

  // All controls follow a commit together two edges later.
  property p_together;
    commit |=> (word_r == $past(word_nxt & ~pcw_pkg::PCW_RSVD_MASK)) ##1
               (if_c.ctl == pcw_pkg::pcw_decode($past(word_r)));
  endproperty
  a_together: assert property (p_together) else $error("controls did not update together"); // see RULE22

  // Without a commit the controls hold.
  property p_hold;
    !commit ##1 !commit |=> $stable(if_c.ctl);
  endproperty
  a_hold: assert property (p_hold) else $error("controls moved without a commit"); // see RULE22

  // Converter power-down follows bit 39.
  property p_dac;
    ##1 (dac_pd == $past(word_r[pcw_pkg::POS_DAC_PD]));
  endproperty
  a_dac: assert property (p_dac) else $error("converter power-down mismatch"); // see RULE2

  // After band-gap power-up the ready flag stays low for a while.
  property p_bg_settle;
    $fell(if_c.ctl.bg_pd) |-> !bg_ready_r [*2];
  endproperty
  a_bg_settle: assert property (p_bg_settle) else $error("band gap ready too early"); // see RULE4

  // Surge disable clears every surge enable.
  property p_surge_off;
    $past(word_r[pcw_pkg::POS_SURGE_OFF]) |->
      (rise_surge == 3'h0) && (fall_surge == 3'h0) && !dflt_surge_en;
  endproperty
  a_surge_off: assert property (p_surge_off) else $error("surge current left on"); // see RULE14 RULE6 RULE7

  // Pin drive enable follows the lock-detect enable one edge later.
  property p_pin_oe;
    ##1 (status_pin_oe == $past(if_c.ctl.lock_en));
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("status pin enable mismatch"); // see RULE8

  // Status mode shows low when locked.
  property p_pin_lock;
    ($past(if_c.ctl.lock_en) && !$past(if_c.ctl.lock_mode)) |-> (status_pin_o == !$past(pll_locked));
  endproperty
  a_pin_lock: assert property (p_pin_lock) else $error("lock status level wrong"); // see RULE9

  // Dividers decode as field plus one, RF divider as a power of two.
  property p_dividers;
    ##1 (ref_div_m == pcw_pkg::pcw_plus_one($past(word_r[15:12]))) &&
        (fb_div_n == pcw_pkg::pcw_plus_one($past(word_r[11:8]))) &&
        (rfdiv_value == (4'h1 << $past(word_r[22:21])));
  endproperty
  a_dividers: assert property (p_dividers) else $error("divider ratio mismatch"); // see RULE16 RULE17 RULE11

  // Charge-pump scale and driver controls follow the word.
  property p_pump_drv;
    ##1 (cp_scale == pcw_pkg::pcw_plus_one({1'b0, $past(word_r[2:0])})) &&
        (drv_pd == $past(word_r[pcw_pkg::POS_DRV_PD])) && (drv_src == $past(word_r[19:18]));
  endproperty
  a_pump_drv: assert property (p_pump_drv) else $error("pump or driver control mismatch"); // see RULE21 RULE12 RULE13

  // A new error wins over a clear in the same cycle.
  property p_set_wins;
    partial_ev |=> partial_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("error flag lost on clear");

  c_commit:   cover property (commit);
  c_partial:  cover property (partial_ev);
  c_bg_wake:  cover property ($fell(if_c.ctl.bg_pd) ##[1:20] bg_ready_r);
  c_leadlag:  cover property (status_pin_oe && if_c.ctl.lock_mode);

endmodule // pcw_clock_path_ctrl

// ==== pcw_ctl_if.sv ====
// Interface that carries the committed word to the decoder and its controls back.
interface pcw_ctl_if;
  logic [39:0]      word;  // Committed control word.
  pcw_pkg::pcw_ctl_t ctl;  // Decoded controls, registered.

  modport regs (output word, input ctl);
  modport dec  (input word, output ctl);
endinterface

// ==== pcw_decoder.sv ====
// Registered decoder that turns the committed control word into clock-path controls.
module pcw_decoder (
  input  wire logic clk,   // System clock.
  input  wire logic nrst,  // Asynchronous reset, active low.
  pcw_ctl_if.dec    bus    // Word in, controls out.
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  // All fields load from the same word in one edge, so they change together.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.ctl <= pcw_pkg::pcw_decode(pcw_pkg::PCW_CTRL_RESET);
    end else begin
      bus.ctl <= pcw_pkg::pcw_decode(bus.word); // see RULE2 RULE5 RULE6 RULE7 RULE10 RULE11 RULE15
    end                                           // see RULE12 RULE13 RULE14 RULE16 RULE17 RULE18 RULE19 RULE20 RULE21
  end

endmodule // pcw_decoder

// ==== pcw_pkg.sv ====
// Package of constants, types and decode functions for the clock-path control word.
package pcw_pkg;

  // ==========================================================================
  // Word geometry and register offsets
  // ==========================================================================
  localparam int            PCW_WORD_W = 40;
  localparam int            PCW_ADDR_W = 8;
  localparam logic [7:0]    PCW_OFS_LO   = 8'h00;  // Control word bits 31:0.
  localparam logic [7:0]    PCW_OFS_HI   = 8'h04;  // Control word bits 39:32, commits the word.
  localparam logic [7:0]    PCW_OFS_STAT = 8'h08;  // Staging and error status.

  // ==========================================================================
  // Reset value and reserved bits
  // ==========================================================================
  localparam logic [39:0]   PCW_CTRL_RESET = 40'h00_0078_0000;
  localparam logic [39:0]   PCW_RSVD_MASK  = 40'h7C_0000_00C0;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int POS_DAC_PD     = 39;
  localparam int POS_BG_PD      = 33;
  localparam int POS_DRIVER_CURRENT_RESISTOR_PIN   = 32;
  localparam int POS_RISE_LSB   = 29;
  localparam int POS_FALL_LSB   = 26;
  localparam int POS_LOCK_EN    = 25;
  localparam int POS_LOCK_MODE  = 24;
  localparam int POS_RFDIV_PD   = 23;
  localparam int POS_RFDIV_LSB  = 21;
  localparam int POS_DRV_PD     = 20;
  localparam int POS_DRV_SRC    = 18;
  localparam int POS_SURGE_OFF  = 17;
  localparam int POS_SYS_BYP    = 16;
  localparam int POS_M_LSB      = 12;
  localparam int POS_N_LSB      = 8;
  localparam int POS_CP_POL     = 5;
  localparam int POS_CP_PD      = 4;
  localparam int POS_CP_QPD     = 3;
  localparam int POS_CP_SCALE   = 0;

  // ==========================================================================
  // Status register bit positions
  // ==========================================================================
  localparam int STAT_LO_STAGED = 0;
  localparam int STAT_PARTIAL   = 1;
  localparam int STAT_RSVD      = 2;
  localparam int STAT_BG_READY  = 3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int PCW_CLK_MHZ          = 100;
  localparam int PCW_BG_SETTLE_MS     = 10;
  localparam int PCW_BG_SETTLE_CYCLES = PCW_BG_SETTLE_MS * 1000 * PCW_CLK_MHZ;
  localparam int PCW_BG_CNT_W         = 20;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PCW_SRC_OFF    = 2'b00,
    PCW_SRC_FB     = 2'b01,
    PCW_SRC_DIVOUT = 2'b10,
    PCW_SRC_DIVIN  = 2'b11
  } pcw_drv_src_t;

  typedef struct packed {
    logic         dac_pd;
    logic         bg_pd;
    logic         drv_int_rset;
    logic [2:0]   rise_surge;
    logic [2:0]   fall_surge;
    logic         dflt_surge_en;
    logic         lock_en;
    logic         lock_mode;
    logic         rfdiv_pd;
    logic [3:0]   rfdiv_value;
    logic         drv_pd;
    pcw_drv_src_t drv_src;
    logic         sys_bypass;
    logic [4:0]   ref_div_m;
    logic [4:0]   fb_div_n;
    logic         cp_invert;
    logic         cp_pd;
    logic         cp_quick_pd;
    logic [4:0]   cp_scale;
  } pcw_ctl_t;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Turns a ratio field into the ratio it selects.
  function automatic logic [4:0] pcw_plus_one(input logic [3:0] f);
    return {1'b0, f} + 5'h01;
  endfunction

  // Splits a committed word into its controls.
  function automatic pcw_ctl_t pcw_decode(input logic [39:0] w);
    pcw_ctl_t c;
    logic     off;
    off             = w[POS_SURGE_OFF];
    c.dac_pd        = w[POS_DAC_PD];
    c.bg_pd         = w[POS_BG_PD];
    c.drv_int_rset  = w[POS_DRIVER_CURRENT_RESISTOR_PIN];
    c.rise_surge    = off ? 3'h0 : w[POS_RISE_LSB +: 3];
    c.fall_surge    = off ? 3'h0 : w[POS_FALL_LSB +: 3];
    c.dflt_surge_en = ~off;
    c.lock_en       = w[POS_LOCK_EN];
    c.lock_mode     = w[POS_LOCK_MODE];
    c.rfdiv_pd      = w[POS_RFDIV_PD];
    c.rfdiv_value   = 4'h1 << w[POS_RFDIV_LSB +: 2];
    c.drv_pd        = w[POS_DRV_PD];
    c.drv_src       = pcw_drv_src_t'(w[POS_DRV_SRC +: 2]);
    c.sys_bypass    = w[POS_SYS_BYP];
    c.ref_div_m     = pcw_plus_one(w[POS_M_LSB +: 4]);
    c.fb_div_n      = pcw_plus_one(w[POS_N_LSB +: 4]);
    c.cp_invert     = w[POS_CP_POL];
    c.cp_pd         = w[POS_CP_PD];
    c.cp_quick_pd   = w[POS_CP_QPD];
    c.cp_scale      = pcw_plus_one({1'b0, w[POS_CP_SCALE +: 3]});
    return c;
  endfunction

endpackage

// ==== pcw_tb.sv ====
// Self-checking testbench for the clock-path control word register block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk, nrst, psel, penable, pwrite, pll_locked, fb_lags_ref, pready, pslverr;
  logic        status_pin_o, status_pin_oe, bg_ready, dac_pd, bg_pd, drv_int_rset, dflt_surge_en;
  logic        rfdiv_pd, drv_pd, sys_bypass, cp_invert, cp_pd, cp_quick_pd, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, rfdiv_value;
  logic [2:0]  rise_surge, fall_surge;
  logic [1:0]  drv_src;
  logic [4:0]  ref_div_m, fb_div_n, cp_scale;
  int          n_errors, n_checks, cyc;
  wire  [36:0] obs = {dac_pd, bg_pd, drv_int_rset, rise_surge, fall_surge, dflt_surge_en, rfdiv_pd,
                      rfdiv_value, drv_pd, drv_src, sys_bypass, ref_div_m, fb_div_n, cp_invert, cp_pd,
                      cp_quick_pd, cp_scale};

  pcw_clock_path_ctrl #(.BG_SETTLE_CYCLES(16)) dut_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pll_locked, .fb_lags_ref, .status_pin_o, .status_pin_oe,
    .bg_ready, .dac_pd, .bg_pd, .drv_int_rset, .rise_surge, .fall_surge, .dflt_surge_en, .rfdiv_pd,
    .rfdiv_value, .drv_pd, .drv_src, .sys_bypass, .ref_div_m, .fb_div_n, .cp_invert, .cp_pd, .cp_quick_pd,
    .cp_scale);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Expected controls worked out bit by bit from a committed word.
  function automatic logic [36:0] ex(input logic [39:0] w);
    logic o;
    o = w[17];
    return {w[39], w[33], w[32], o ? 3'h0 : w[31:29], o ? 3'h0 : w[28:26], ~o, w[23], 4'h1 << w[22:21],
            w[20], w[19:18], w[16], {1'b0, w[15:12]} + 5'h01, {1'b0, w[11:8]} + 5'h01, w[5], w[4], w[3],
            {2'b00, w[2:0]} + 5'h01};
  endfunction

  // Compares one value and counts the outcome.
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Writes a whole word, low half then high byte, and lets the controls settle.
  task automatic wr40(input logic [39:0] w);
    apb(1'b1, 8'h00, w[31:0], 4'hF);
    apb(1'b1, 8'h04, {24'h000000, w[39:32]}, 4'h1);
    repeat (2) @(posedge clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Low half alone changes nothing; the high byte commits every field at once.
  task automatic s_word();
    apb(1'b1, 8'h00, 32'hACA5_F02F, 4'hF);
    repeat (2) @(posedge clk);
    chk(obs, ex(40'h00_0078_0000));
    apb(1'b1, 8'h04, 32'h0000_0081, 4'h1);
    repeat (2) @(posedge clk);
    chk(obs, ex(40'h81_ACA5_F02F));
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'hACA5_F02F);
  endtask

  // Every divide code with the surge kill bit set, then a refused partial word and a bad address.
  task automatic s_div_refuse();
    for (int i = 0; i < 4; i++) begin
      wr40({8'h00, 8'hFC, 1'b0, 2'(i), 21'h020018});
      chk(obs, ex({8'h00, 8'hFC, 1'b0, 2'(i), 21'h020018}));
    end
    apb(1'b1, 8'h00, 32'h0000_0F1F, 4'h3);
    apb(1'b1, 8'h04, 32'h0000_0080, 4'h1);
    repeat (2) @(posedge clk);
    chk(obs, ex({8'h00, 8'hFC, 1'b0, 2'h3, 21'h020018}));
    apb(1'b0, 8'h08, 32'h0, 4'h0);
    chk(rd[1], 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 4'h0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask

  // Lock-detect pin in both meanings against both input levels.
  task automatic s_lock();
    for (int i = 0; i < 4; i++) begin
      wr40({15'h0001, i[1], 24'h78_0000});
      pll_locked <= i[0]; fb_lags_ref <= i[0];
      repeat (3) @(posedge clk);
      chk({status_pin_oe, status_pin_o}, {1'b1, i[1] ? i[0] : ~i[0]});
    end
  endtask

  // Band gap held down, then released and given its settle time.
  task automatic s_bg();
    wr40(40'h02_0078_0000);
    @(posedge clk);
    chk({bg_pd, bg_ready}, 2'b10);
    wr40(40'h00_0078_0000);
    chk(bg_ready, 1'b0);
    repeat (30) @(posedge clk);
    chk(bg_ready, 1'b1);
  endtask

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end

  // Reset, defaults, then each scenario in turn.
  initial begin
    {psel, penable, pwrite, pll_locked, fb_lags_ref, nrst} = 6'h00;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(obs, ex(40'h00_0078_0000));
    s_word();
    s_div_refuse();
    s_lock();
    s_bg();
    conclude();
  end
endmodule // testbench
